/* hw/pbw_pkg.sv */
/*
 * pbw_pkg: constants, carrier structs and state types for the right-port
 * bus-width controller of an asynchronous dual-port memory.
 * assumes: a single 100 MHz clock and an apb slave port of 8 address bits.
 */
package pbw_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int LANE_W = 9;
	localparam int LANES  = 4;
	localparam int DW     = LANE_W * LANES;
	localparam int AW     = 15;
	localparam int PAW    = 8;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS    = 10;
	localparam int T_ACC_NS  = 15;
	localparam int ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int CFG_CYC   = 1;
	localparam int SYNC_CYC  = 2;

	// ------------------------------------------------------------
	// register offsets and fields
	// ------------------------------------------------------------
	localparam logic [PAW-1:0] OFS_CTRL     = 8'h00;
	localparam logic [PAW-1:0] OFS_ADDR     = 8'h04;
	localparam logic [PAW-1:0] OFS_WDATA_LO = 8'h08;
	localparam logic [PAW-1:0] OFS_WDATA_HI = 8'h0C;
	localparam logic [PAW-1:0] OFS_CMD      = 8'h10;
	localparam logic [PAW-1:0] OFS_STATUS   = 8'h14;
	localparam logic [PAW-1:0] OFS_RDATA_LO = 8'h18;
	localparam logic [PAW-1:0] OFS_RDATA_HI = 8'h1C;

	localparam int CTRL_MATCH_BIT = 0;
	localparam int CTRL_SIZE_BIT  = 1;
	localparam int ADDR_HALF_BIT  = 15;
	localparam int ADDR_QUART_BIT = 16;
	localparam int CMD_GO_BIT     = 0;
	localparam int CMD_WRITE_BIT  = 1;
	localparam int CMD_FLAG_BIT   = 2;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_DONE_BIT  = 1;
	localparam int STAT_ERR_BIT   = 2;
	localparam int STAT_WAIT_BIT  = 3;
	localparam int STAT_MODE_LSB  = 4;

	// lane masks: pins carried in each width
	localparam logic [DW-1:0] MASK_LONG = 36'hF_FFFF_FFFF;
	localparam logic [DW-1:0] MASK_WORD = 36'h0_0003_FFFF;
	localparam logic [DW-1:0] MASK_BYTE = 36'h0_0000_01FF;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	// encoding is {width_match_select, width_size_select}
	typedef enum logic [1:0] {
		MODE_LONG    = 2'b00,
		MODE_DISABLE = 2'b01,
		MODE_WORD    = 2'b10,
		MODE_BYTE    = 2'b11
	} pbw_mode_t;

	typedef enum logic [2:0] {
		PH_IDLE    = 3'b000,
		PH_SETUP   = 3'b001,
		PH_STROBE  = 3'b010,
		PH_SAMPLE  = 3'b011,
		PH_RECOVER = 3'b100
	} pbw_phase_t;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic          half_select;
		logic          quarter_select;
		logic          ce_n;
		logic          rw_n;
		logic          oe_n;
		logic          flag_access_select_n;
		logic          width_match_select;
		logic          width_size_select;
		logic [DW-1:0] io_out;
		logic [DW-1:0] io_oe;
	} pbw_pins_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} pbw_apb_out_t;

	typedef struct packed {
		pbw_phase_t    phase;
		logic [2:0]    cnt;
		logic [1:0]    settle;
		pbw_mode_t     mode;
		logic [AW-1:0] addr;
		logic          half;
		logic          quarter;
		logic [DW-1:0] wdata;
		logic [DW-1:0] rdata;
		logic          wr;
		logic          flag;
		logic          done;
		logic          err;
		pbw_pins_t     pins;
		pbw_apb_out_t  apb;
	} pbw_state_t;

	localparam pbw_pins_t PINS_RST = '{
		addr: '0, half_select: 1'b0, quarter_select: 1'b0, ce_n: 1'b1,
		rw_n: 1'b1, oe_n: 1'b1, flag_access_select_n: 1'b1,
		width_match_select: 1'b0, width_size_select: 1'b0,
		io_out: '0, io_oe: '0};

	localparam pbw_state_t STATE_RST = '{
		phase: PH_IDLE, cnt: '0, settle: 2'(CFG_CYC), mode: MODE_LONG,
		addr: '0, half: 1'b0, quarter: 1'b0, wdata: '0, rdata: '0,
		wr: 1'b0, flag: 1'b0, done: 1'b0, err: 1'b0, pins: PINS_RST,
		apb: '0};

endpackage

/* hw/pbw_pin_sync.sv */
/*
 * pbw_pin_sync: two-flop synchroniser for the memory data pins.
 * assumes: input levels come from an unclocked device; the first stage
 * is read by the second stage only.
 */
`timescale 1ns/100ps
`default_nettype none

module pbw_pin_sync #(
	parameter int W = 36
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// pins and synchronised levels
	input  wire logic [W-1:0] pin_in,
	output var  logic [W-1:0] pin_sync
);

	logic [W-1:0] meta_ff;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			meta_ff  <= '0;
			pin_sync <= '0;
		end
		else
		begin
			meta_ff  <= pin_in;
			pin_sync <= meta_ff;
		end
	end

endmodule

`default_nettype wire

/* hw/pbw_host.sv */
/*
 * pbw_host: apb-controlled host for the width-matched right port of an
 * asynchronous dual-port memory; drives its select, address, strobe and
 * data pins and returns read data to software.
 * assumes: the memory answers within the access time held in pbw_pkg;
 * io pins are resolved outside from io_out and io_oe.
 */
// Chosen here: the register addresses and register access over APB.
// What this block does
// - width-match select held steady while operating
// - width-size select held steady while operating
// - half select obeys address timing in word
// - byte selects obey ordinary address timing
// - ignored inputs driven to definite levels
// - selects settle a cycle before first access
`timescale 1ns/100ps
`default_nettype none

module pbw_host (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// apb slave
	input  wire logic [7:0]            paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output var  logic [31:0]           prdata,
	output var  logic                  pready,
	output var  logic                  pslverr,
	// memory right port
	output var  pbw_pkg::pbw_pins_t    rp_pins,
	input  wire logic [pbw_pkg::DW-1:0] rp_io_in
);
	import pbw_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	pbw_state_t    s_ff;
	pbw_state_t    nxt_s;
	logic [DW-1:0] io_sync;
	logic [DW-1:0] lane_mask;
	logic [31:0]   rd_val;
	logic          rd_ok;
	logic          acc;

	pbw_pin_sync #(
		.W (DW)
	) u_sync (
		.clk      (clk),
		.reset    (reset),
		.pin_in   (rp_io_in),
		.pin_sync (io_sync)
	);

	// ------------------------------------------------------------
	// lane mask of the selected width
	// ------------------------------------------------------------
	always_comb
	begin
		case (s_ff.mode)
			MODE_LONG: lane_mask = MASK_LONG;
			MODE_WORD: lane_mask = MASK_WORD;
			MODE_BYTE: lane_mask = MASK_BYTE;
			default:   lane_mask = '0;
		endcase
		if (s_ff.flag)
			lane_mask = MASK_BYTE;             // flag value sits on lane 0
	end

	// ------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------
	always_comb
	begin
		rd_val = '0;
		rd_ok  = 1'b1;
		case (paddr)
			OFS_CTRL:
			begin
				rd_val[CTRL_MATCH_BIT] = s_ff.mode[1];
				rd_val[CTRL_SIZE_BIT]  = s_ff.mode[0];
			end
			OFS_ADDR:     rd_val[16:0] = {s_ff.quarter, s_ff.half, s_ff.addr};
			OFS_WDATA_LO: rd_val = s_ff.wdata[31:0];
			OFS_WDATA_HI: rd_val[DW-33:0] = s_ff.wdata[DW-1:32];
			OFS_CMD:      rd_val = '0;
			OFS_STATUS:
			begin
				rd_val[STAT_BUSY_BIT] = (s_ff.phase != PH_IDLE);
				rd_val[STAT_DONE_BIT] = s_ff.done;
				rd_val[STAT_ERR_BIT]  = s_ff.err;
				rd_val[STAT_WAIT_BIT] = (s_ff.settle != 2'h0);
				rd_val[STAT_MODE_LSB +: 2] = s_ff.mode;
			end
			OFS_RDATA_LO: rd_val = s_ff.rdata[31:0];
			OFS_RDATA_HI: rd_val[DW-33:0] = s_ff.rdata[DW-1:32];
			default:      rd_ok = 1'b0;
		endcase
	end

	assign acc = psel && penable && s_ff.apb.pready;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.apb.pready  = 1'b0;
		nxt_s.apb.pslverr = 1'b0;
		// one wait-free answer: ready in the first access cycle
		if (psel && !penable)
		begin
			nxt_s.apb.pready  = 1'b1;
			nxt_s.apb.pslverr = !rd_ok;
			nxt_s.apb.prdata  = rd_ok ? rd_val : '0;
		end
		if (s_ff.settle != 2'h0)
			nxt_s.settle = s_ff.settle - 2'h1;

		if (acc && pwrite && !s_ff.apb.pslverr)
		begin
			case (paddr)
				OFS_CTRL:
				begin
					// width changes only between accesses, so pins stay steady
					if (s_ff.phase == PH_IDLE)
					begin
						nxt_s.mode = pbw_mode_t'({pwdata[CTRL_MATCH_BIT],
							pwdata[CTRL_SIZE_BIT]});
						nxt_s.settle = 2'(CFG_CYC);
						// lane selects of the old width must not linger in the new one
						nxt_s.pins.half_select    = 1'b0;
						nxt_s.pins.quarter_select = 1'b0;
					end
				end
				OFS_ADDR:
				begin
					nxt_s.addr    = pwdata[AW-1:0];
					nxt_s.half    = pwdata[ADDR_HALF_BIT];
					nxt_s.quarter = pwdata[ADDR_QUART_BIT];
				end
				OFS_WDATA_LO: nxt_s.wdata[31:0] = pwdata;
				OFS_WDATA_HI: nxt_s.wdata[DW-1:32] = pwdata[DW-33:0];
				OFS_STATUS:
				begin
					if (pwdata[STAT_DONE_BIT])
						nxt_s.done = 1'b0;
					if (pwdata[STAT_ERR_BIT])
						nxt_s.err = 1'b0;
				end
				OFS_CMD:
				begin
					// go while busy or settling is dropped
					if (pwdata[CMD_GO_BIT] && s_ff.phase == PH_IDLE &&
						s_ff.settle == 2'h0)
					begin
						if (s_ff.mode == MODE_DISABLE && !pwdata[CMD_FLAG_BIT])
							nxt_s.err = 1'b1;
						else
						begin
							nxt_s.wr    = pwdata[CMD_WRITE_BIT];
							nxt_s.flag  = pwdata[CMD_FLAG_BIT];
							nxt_s.phase = PH_SETUP;
						end
					end
				end
				default: ;
			endcase
		end

		// sequencer: events set flags after the clears above, so set wins
		case (s_ff.phase)
			PH_SETUP:
			begin
				nxt_s.pins.addr = s_ff.addr;
				nxt_s.pins.half_select =
					(s_ff.mode[1] && !s_ff.flag) ? s_ff.half : 1'b0;
				nxt_s.pins.quarter_select =
					(s_ff.mode == MODE_BYTE && !s_ff.flag) ? s_ff.quarter : 1'b0;
				nxt_s.pins.ce_n = s_ff.flag;
				nxt_s.pins.flag_access_select_n = !s_ff.flag;
				nxt_s.pins.io_out = s_ff.wdata & lane_mask;
				nxt_s.pins.io_oe  = s_ff.wr ? lane_mask : '0;
				nxt_s.cnt   = 3'(ACC_CYC);
				nxt_s.phase = PH_STROBE;
			end
			PH_STROBE:
			begin
				// address and selects stay frozen through the strobe
				nxt_s.pins.rw_n = !s_ff.wr;
				nxt_s.pins.oe_n = s_ff.wr;
				if (s_ff.pins.rw_n == s_ff.wr)
					nxt_s.cnt = s_ff.cnt;
				else if (s_ff.cnt == 3'h1)
				begin
					nxt_s.pins.rw_n = 1'b1;
					nxt_s.cnt   = 3'(SYNC_CYC);
					nxt_s.phase = s_ff.wr ? PH_RECOVER : PH_SAMPLE;
				end
				else
					nxt_s.cnt = s_ff.cnt - 3'h1;
			end
			PH_SAMPLE:
			begin
				// sync delay: hold output enable until the pins reach us
				if (s_ff.cnt == 3'h1)
				begin
					nxt_s.rdata = io_sync & lane_mask;
					nxt_s.pins.oe_n = 1'b1;
					nxt_s.phase = PH_RECOVER;
				end
				else
					nxt_s.cnt = s_ff.cnt - 3'h1;
			end
			PH_RECOVER:
			begin
				nxt_s.pins.ce_n = 1'b1;
				nxt_s.pins.flag_access_select_n = 1'b1;
				nxt_s.pins.io_oe = '0;
				nxt_s.done  = 1'b1;
				nxt_s.phase = PH_IDLE;
			end
			default: ;
		endcase
		// selects follow the control register, steady outside settling
		nxt_s.pins.width_match_select = nxt_s.mode[1];
		nxt_s.pins.width_size_select  = nxt_s.mode[0];
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			s_ff <= STATE_RST;
		else
			s_ff <= nxt_s;
	end

	assign prdata  = s_ff.apb.prdata;
	assign pready  = s_ff.apb.pready;
	assign pslverr = s_ff.apb.pslverr;
	assign rp_pins = s_ff.pins;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_match_steady_busy: assert property (s_ff.phase != PH_IDLE |=> $stable(rp_pins.width_match_select)) else $error("match select moved during access");
	a_size_steady_busy: assert property (s_ff.phase != PH_IDLE |=> $stable(rp_pins.width_size_select)) else $error("size select moved during access");
	a_select_settle: assert property ($changed({rp_pins.width_match_select, rp_pins.width_size_select}) |-> rp_pins.ce_n && rp_pins.flag_access_select_n ##1 rp_pins.ce_n && rp_pins.flag_access_select_n) else $error("access within a cycle of select change");
	a_disable_no_data: assert property (s_ff.mode == MODE_DISABLE |-> rp_pins.ce_n && rp_pins.io_oe[DW-1:9] == '0) else $error("data access in disable mode");
	a_word_upper_quiet: assert property (s_ff.mode == MODE_WORD |-> rp_pins.io_oe[DW-1:18] == '0 && !rp_pins.quarter_select) else $error("word mode drives upper pins");
	a_byte_upper_quiet: assert property (s_ff.mode == MODE_BYTE |-> rp_pins.io_oe[DW-1:9] == '0) else $error("byte mode drives upper pins");
	a_long_no_lanes: assert property (s_ff.mode == MODE_LONG |-> !rp_pins.half_select && !rp_pins.quarter_select) else $error("lane selects moved in long mode");
	a_strobe_width: assert property ($fell(rp_pins.rw_n) |-> (!rp_pins.rw_n)[*2] ##1 rp_pins.rw_n) else $error("write strobe not two cycles");
	a_addr_held: assert property (!rp_pins.rw_n || (s_ff.phase == PH_SAMPLE) |=> $stable({rp_pins.addr, rp_pins.half_select, rp_pins.quarter_select})) else $error("address moved in strobe");
	a_write_data_held: assert property ($rose(rp_pins.rw_n) && s_ff.wr |-> $stable(rp_pins.io_out) ##1 rp_pins.io_oe == '0) else $error("write data released early");
	a_apb_answer: assert property (psel && !penable |=> pready) else $error("apb answer missing");
	a_go_to_done: assert property (s_ff.phase == PH_SETUP |-> ##[3:8] s_ff.phase == PH_IDLE) else $error("access did not finish");

	c_word_write: cover property (s_ff.mode == MODE_WORD && $fell(rp_pins.rw_n));
	c_byte_read: cover property (s_ff.mode == MODE_BYTE && s_ff.phase == PH_SAMPLE);
	c_flag_disable: cover property (s_ff.mode == MODE_DISABLE && !rp_pins.flag_access_select_n);
	c_long_read: cover property (s_ff.mode == MODE_LONG && $fell(rp_pins.oe_n));

endmodule

`default_nettype wire

/* verif/pbw_mem_model.sv */
/*
 * pbw_mem_model: behavioural right port of the dual-port memory, 16 words.
 * assumes: pins come from pbw_host; io is the resolved pin level.
 */
`timescale 1ns/100ps
`default_nettype none

module pbw_mem_model (
	// host pins and resolved data
	input  wire pbw_pkg::pbw_pins_t p,
	input  wire logic [35:0]        io,
	// device drive
	output logic [35:0]             dev_d,
	output logic [35:0]             dev_oe
);
	import pbw_pkg::*;
	logic [35:0] mem [16];
	logic        flag_ff = 1'b1;
	logic [1:0]  md;
	logic [1:0]  ln;
	logic [35:0] word;

	assign md = {p.width_match_select, p.width_size_select};
	// word mode picks a lane pair, byte mode one nine-bit lane of four
	assign ln = (md == MODE_WORD) ? {p.half_select, 1'b0} : {p.half_select, p.quarter_select};
	assign word = mem[p.addr[3:0]] >> (9 * ln);

	// write on the rising edge of the strobe, like the real array
	always @(posedge p.rw_n)
	begin
		if (p.flag_access_select_n == 1'b0)
			flag_ff <= io[0];
		else if (p.ce_n == 1'b0)
			case (md)
				MODE_LONG: mem[p.addr[3:0]] <= io;
				MODE_WORD: mem[p.addr[3:0]][9*ln +: 18] <= io[17:0];
				MODE_BYTE: mem[p.addr[3:0]][9*ln +: 9] <= io[8:0];
				default: ;
			endcase
	end

	always_comb
	begin
		dev_oe = '0;
		dev_d  = word;
		if (p.oe_n == 1'b0 && p.flag_access_select_n == 1'b0)
		begin
			dev_oe = MASK_BYTE;
			dev_d  = {27'h0, {9{flag_ff}}};
		end
		else if (p.oe_n == 1'b0 && p.ce_n == 1'b0)
			case (md)
				MODE_LONG: dev_oe = MASK_LONG;
				MODE_WORD: dev_oe = MASK_WORD;
				MODE_BYTE: dev_oe = MASK_BYTE;
				default:   dev_oe = '0;
			endcase
	end
endmodule
`default_nettype wire

/* verif/port_bus_width_matcher_test.sv */
/*
 * port_bus_width_matcher_test: apb-driven bench of pbw_host against a
 * memory model; reads are checked through a queue of expected answers.
 * assumes: pbw_host answers every apb access in one cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module port_bus_width_matcher_test;
	import pbw_pkg::*;
	logic               clk = 1'b0;
	logic               reset = 1'b1;
	logic [7:0]         paddr = '0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [31:0]        pwdata = '0;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	pbw_pins_t          rp_pins;
	logic [35:0]        io_w;
	logic [35:0]        dev_d;
	logic [35:0]        dev_oe;
	// released pins show a level that flips every cycle, never the last value
	logic [35:0]        fill = 36'h5_A5A5_A5A5;
	logic               tchk = 1'b0;
	logic [32:0]        exp_q [$];
	logic [32:0]        e;
	logic [35:0]        pmask;
	logic [31:0]        seed = 32'd71362;
	logic [35:0]        d;
	int                 failures = 0;
	int                 checked = 0;

	always #5 clk = ~clk;
	always @(posedge clk) fill <= ~fill;
	assign io_w = (rp_pins.io_oe & rp_pins.io_out) | (dev_oe & dev_d)
		| (~rp_pins.io_oe & ~dev_oe & fill);

	pbw_host uut (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rp_pins(rp_pins), .rp_io_in(io_w));
	pbw_mem_model mem (.p(rp_pins), .io(io_w), .dev_d(dev_d), .dev_oe(dev_oe));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic close_out();
		$display("counts: checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
		input logic c, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		tchk <= c;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		tchk <= 1'b0;
		if (n >= 20)
		begin
			failures++;
			$display("BAD %0t apb no ready", $time);
			close_out();
		end
	endtask

	task automatic expect_rd(input logic [7:0] a, input logic [32:0] x);
		logic [31:0] r;
		exp_q.push_back(x);
		apb(a, 1'b0, 32'h0, 1'b1, r);
	endtask

	// modes change only while idle, then settle before the next go
	task automatic set_mode(input logic [1:0] m);
		logic [31:0] r;
		apb(OFS_CTRL, 1'b1, {30'h0, m[0], m[1]}, 1'b0, r);
		repeat (3) @(posedge clk);
	endtask

	task automatic op(input logic [14:0] a, input logic h, input logic q, input logic w,
		input logic f, input logic [35:0] wd, input logic [31:0] st);
		logic [31:0] r;
		int n;
		n = 0;
		apb(OFS_ADDR, 1'b1, {15'h0, q, h, a}, 1'b0, r);
		apb(OFS_WDATA_LO, 1'b1, wd[31:0], 1'b0, r);
		apb(OFS_WDATA_HI, 1'b1, {28'h0, wd[35:32]}, 1'b0, r);
		apb(OFS_CMD, 1'b1, {29'h0, f, w, 1'b1}, 1'b0, r);
		do
		begin
			apb(OFS_STATUS, 1'b0, 32'h0, 1'b0, r);
			n++;
		end while (r[2:1] == 2'b00 && n < 30);
		if (n >= 30)
		begin
			failures++;
			$display("BAD %0t access never finished", $time);
			close_out();
		end
		expect_rd(OFS_STATUS, {1'b0, st});
		apb(OFS_STATUS, 1'b1, 32'h6, 1'b0, r);
	endtask

	task automatic rd36(input logic [35:0] x);
		expect_rd(OFS_RDATA_LO, {1'b0, x[31:0]});
		expect_rd(OFS_RDATA_HI, {1'b0, 28'h0, x[35:32]});
	endtask

	always @(posedge clk)
		if (psel && penable && pready === 1'b1 && tchk)
		begin
			e = exp_q.pop_front();
			checked++;
			if ({pslverr, prdata} !== e)
			begin
				failures++;
				$display("BAD %0t read %h want %h", $time, {pslverr, prdata}, e);
			end
		end

	// data pins outside the selected width must stay undriven while ce_n is low
	always_comb
		case ({rp_pins.width_match_select, rp_pins.width_size_select})
			MODE_LONG: pmask = MASK_LONG;
			MODE_WORD: pmask = MASK_WORD;
			MODE_BYTE: pmask = MASK_BYTE;
			default:   pmask = '0;
		endcase
	always @(negedge clk)
		if (rp_pins.ce_n === 1'b0 && (rp_pins.io_oe & ~pmask) !== 36'h0)
		begin
			failures++;
			$display("BAD %0t unused pins driven", $time);
		end

	initial
	begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		expect_rd(OFS_STATUS, 33'h0);
		expect_rd(8'h20, {1'b1, 32'h0});
		for (int m = 0; m < 4; m++)
		begin
			set_mode(m[1:0]);
			expect_rd(OFS_STATUS, {27'h0, m[1:0], 4'h0});
			expect_rd(OFS_CTRL, {31'h0, m[0], m[1]});
		end
		$display("test modes done");
		set_mode(MODE_LONG);
		seed = xs(seed);
		d[35:32] = seed[3:0];
		seed = xs(seed);
		d[31:0] = seed;
		op(15'h1, 1'b1, 1'b1, 1'b1, 1'b0, d, 32'h2);
		op(15'h1, 1'b0, 1'b0, 1'b0, 1'b0, 36'h0, 32'h2);
		rd36(d);
		$display("test long done");
		set_mode(MODE_WORD);
		seed = xs(seed);
		d[35:32] = seed[7:4];
		d[31:0] = xs(seed);
		op(15'h2, 1'b0, seed[0], 1'b1, 1'b0, {18'h0, d[17:0]}, 32'h22);
		op(15'h2, 1'b1, seed[1], 1'b1, 1'b0, {18'h0, d[35:18]}, 32'h22);
		for (int h = 0; h < 2; h++)
		begin
			op(15'h2, h[0], ~seed[h], 1'b0, 1'b0, 36'h0, 32'h22);
			rd36({18'h0, d[18*h +: 18]});
		end
		$display("test word done");
		set_mode(MODE_BYTE);
		seed = xs(seed);
		d = {seed[3:0], xs(seed)};
		for (int k = 0; k < 4; k++)
			op(15'h3, k[1], k[0], 1'b1, 1'b0, {27'h0, d[9*k +: 9]}, 32'h32);
		for (int k = 3; k >= 0; k--)
		begin
			op(15'h3, k[1], k[0], 1'b0, 1'b0, 36'h0, 32'h32);
			rd36({27'h0, d[9*k +: 9]});
		end
		set_mode(MODE_LONG);
		op(15'h3, 1'b0, 1'b0, 1'b0, 1'b0, 36'h0, 32'h2);
		rd36(d);
		$display("test byte done");
		set_mode(MODE_DISABLE);
		op(15'h3, 1'b0, 1'b0, 1'b0, 1'b0, 36'h0, 32'h14);
		op(15'h0, 1'b0, 1'b0, 1'b1, 1'b1, 36'h0, 32'h12);
		op(15'h0, 1'b0, 1'b0, 1'b0, 1'b1, 36'h0, 32'h12);
		rd36(36'h0);
		op(15'h0, 1'b0, 1'b0, 1'b1, 1'b1, 36'h1, 32'h12);
		op(15'h0, 1'b0, 1'b0, 1'b0, 1'b1, 36'h0, 32'h12);
		rd36(36'h1FF);
		$display("test disable done");
		close_out();
	end
endmodule
`default_nettype wire
